/* inc/dimc_defs.svh */
`ifndef DIMC_DEFS_SVH
`define DIMC_DEFS_SVH

`define DIMC_MASK_OFFSET 12'h000
`define DIMC_CLEAR_OFFSET 12'h004
`define DIMC_FLAGS_OFFSET 12'h008
`define DIMC_ACTIVE_OFFSET 12'h00c
`define DIMC_DONE_LSB 0
`define DIMC_ERR_LSB 4
`define DIMC_MASK_RESET 8'h00
`define DIMC_FLAGS_RESET 8'h00
`define DIMC_CLEAR_READ 32'h00000000

`endif

/* inc/dimc_pkg.sv */
package dimc_pkg;

  typedef struct packed {
    logic [3:0] err;
    logic [3:0] done;
  } dimc_flags_s;

  typedef struct packed {
    logic [11:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } dimc_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } dimc_apb_rsp_s;

  typedef struct packed {
    dimc_flags_s mask;
    dimc_flags_s flags;
    logic [3:0] active;
    logic irq;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } dimc_state_s;

endpackage

/* hw/dimc_irq_ctl.sv */
// Summary of operation
// - One combined interrupt output covers all four streams.
// - Interrupt rises only for status flags whose enable bit is set.
// - Mask bits 3..0 enable done interrupts of streams 3..0.
// - Mask bits 7..4 enable error interrupts of streams 3..0.
// - All mask enables are zero after reset.
// - Mask bits 31..8 read zero; software writes zero there.
// - A single mask register serves all four streams.
// - Writing one to a clear bit resets the matching flag.
// - Writing zero to a clear bit changes nothing.
// - The clear register is write-only; its reads return zero.
// - Clear bits 3..0 clear done flags, bits 7..4 clear error flags.
// - A done flag sets when its stream finishes its transfer.
// - An error flag sets when a stream transfer aborts on error.
// - Status holds error flags in 7..4, done flags in 3..0, at 0x008.
//
// Decided for this implementation: the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "dimc_defs.svh"

module dimc_irq_ctl
  import dimc_pkg::*;
(
  input wire logic clock, // 10 MHz bus clock
  input wire logic resetn, // Async reset, active low
  input wire logic [11:0] paddr, // APB byte address
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction, high write
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic [3:0] stream_done, // Pulse: stream finished transfer
  input wire logic [3:0] stream_error, // Pulse: stream aborted on error
  input wire logic [3:0] stream_active, // Level: stream transfer running
  output logic combined_irq, // Level to interrupt controller
  output logic [7:0] dma_stream_flags // Error and done flags
);

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic is_addr(input logic [11:0] a,
                                   input logic [11:0] off);
    is_addr = (a[11:2] == off[11:2]);
  endfunction

  function automatic logic any_enabled(input dimc_flags_s f,
                                       input dimc_flags_s m);
    any_enabled = |(f & m);
  endfunction

  dimc_state_s state_reg;
  dimc_state_s state_next;
  dimc_flags_s set_ev;
  dimc_flags_s clr_ev;
  dimc_flags_s wr_flags;
  logic [3:0] act_meta_reg;
  logic setup;
  logic wr_en;

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    state_next = state_reg;
    setup = psel && !penable;
    wr_en = psel && penable && pwrite && state_reg.pready;
    wr_flags = pwdata[7:0];
    set_ev = {stream_error, stream_done};
    clr_ev = '0;
    state_next.pready = 1'b0;
    state_next.pslverr = 1'b0;
    if (setup) begin
      state_next.pready = 1'b1;
      state_next.prdata = 32'h00000000;
      if (is_addr(paddr, `DIMC_MASK_OFFSET)) begin
        state_next.prdata = {24'h000000, state_reg.mask};
      end else if (is_addr(paddr, `DIMC_CLEAR_OFFSET)) begin
        state_next.prdata = `DIMC_CLEAR_READ;
      end else if (is_addr(paddr, `DIMC_FLAGS_OFFSET)) begin
        state_next.prdata = {24'h000000, state_reg.flags};
      end else if (is_addr(paddr, `DIMC_ACTIVE_OFFSET)) begin
        state_next.prdata = {28'h0000000, state_reg.active};
      end else begin
        state_next.pslverr = 1'b1;
      end
    end
    if (wr_en) begin
      if (is_addr(paddr, `DIMC_MASK_OFFSET)) begin
        state_next.mask = wr_flags;
      end else if (is_addr(paddr, `DIMC_CLEAR_OFFSET)) begin
        clr_ev = wr_flags;
      end
    end
    // Set beats clear in the same cycle
    state_next.flags = (state_reg.flags & ~clr_ev) | set_ev;
    state_next.active = act_meta_reg;
    state_next.irq = any_enabled(state_next.flags, state_next.mask);
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_reg.mask <= `DIMC_MASK_RESET;
      state_reg.flags <= `DIMC_FLAGS_RESET;
      state_reg.active <= 4'h0;
      state_reg.irq <= 1'b0;
      state_reg.prdata <= 32'h00000000;
      state_reg.pready <= 1'b0;
      state_reg.pslverr <= 1'b0;
      act_meta_reg <= 4'h0;
    end else begin
      state_reg <= state_next;
      act_meta_reg <= stream_active;
    end
  end

  assign prdata = state_reg.prdata;
  assign pready = state_reg.pready;
  assign pslverr = state_reg.pslverr;
  assign combined_irq = state_reg.irq;
  assign dma_stream_flags = state_reg.flags;

  // ************************************************************
  // Checks: bus side
  // ************************************************************
  a_ready_one: assert property (
    @(posedge clock) disable iff (!resetn)
    setup |=> pready ##1 !pready)
    else $error("pready not a single cycle");

  a_ready_after_setup: assert property (
    @(posedge clock) disable iff (!resetn)
    !setup |=> !pready)
    else $error("pready without a setup cycle");

  a_mask_readback: assert property (
    @(posedge clock) disable iff (!resetn)
    (setup && !pwrite && is_addr(paddr, `DIMC_MASK_OFFSET))
      |=> pready && prdata[31:8] == 24'h000000)
    else $error("mask read high bits not zero");

  a_flags_readback: assert property (
    @(posedge clock) disable iff (!resetn)
    (setup && !pwrite && is_addr(paddr, `DIMC_FLAGS_OFFSET))
      |=> pready && prdata == {24'h000000, $past(dma_stream_flags)})
    else $error("status read does not show the flags");

  a_unmapped_err: assert property (
    @(posedge clock) disable iff (!resetn)
    (setup && !is_addr(paddr, `DIMC_MASK_OFFSET)
     && !is_addr(paddr, `DIMC_CLEAR_OFFSET)
     && !is_addr(paddr, `DIMC_FLAGS_OFFSET)
     && !is_addr(paddr, `DIMC_ACTIVE_OFFSET))
      |=> pready && pslverr && prdata == 32'h00000000)
    else $error("unmapped access not refused");

  a_mapped_no_err: assert property (
    @(posedge clock) disable iff (!resetn)
    (setup && (is_addr(paddr, `DIMC_MASK_OFFSET)
     || is_addr(paddr, `DIMC_CLEAR_OFFSET)
     || is_addr(paddr, `DIMC_FLAGS_OFFSET)
     || is_addr(paddr, `DIMC_ACTIVE_OFFSET)))
      |=> pready && !pslverr)
    else $error("mapped access answered with error");

  a_mask_write: assert property (
    @(posedge clock) disable iff (!resetn)
    (wr_en && is_addr(paddr, `DIMC_MASK_OFFSET))
      |=> state_reg.mask == $past(pwdata[7:0]))
    else $error("mask write not stored");

  a_mask_hold: assert property (
    @(posedge clock) disable iff (!resetn)
    !(wr_en && is_addr(paddr, `DIMC_MASK_OFFSET))
      |=> $stable(state_reg.mask))
    else $error("mask changed without a write");

  // ************************************************************
  // Checks: status flags
  // ************************************************************
  a_done_flag_set: assert property (
    @(posedge clock) disable iff (!resetn)
    stream_done[0] |=> dma_stream_flags[0])
    else $error("stream 0 done flag not set");

  a_done_set_s1: assert property (
    @(posedge clock) disable iff (!resetn)
    stream_done[1] |=> dma_stream_flags[1])
    else $error("stream 1 done flag not set");

  a_done_set_s2: assert property (
    @(posedge clock) disable iff (!resetn)
    stream_done[2] |=> dma_stream_flags[2])
    else $error("stream 2 done flag not set");

  a_done_set_s3: assert property (
    @(posedge clock) disable iff (!resetn)
    stream_done[3] |=> dma_stream_flags[3])
    else $error("stream 3 done flag not set");

  a_err_set_s0: assert property (
    @(posedge clock) disable iff (!resetn)
    stream_error[0] |=> dma_stream_flags[4])
    else $error("stream 0 error flag not set");

  a_err_set_s1: assert property (
    @(posedge clock) disable iff (!resetn)
    stream_error[1] |=> dma_stream_flags[5])
    else $error("stream 1 error flag not set");

  a_err_set_s2: assert property (
    @(posedge clock) disable iff (!resetn)
    stream_error[2] |=> dma_stream_flags[6])
    else $error("stream 2 error flag not set");

  a_err_flag_set: assert property (
    @(posedge clock) disable iff (!resetn)
    stream_error[3] |=> dma_stream_flags[7])
    else $error("stream 3 error flag not set");

  a_done_clear_s0: assert property (
    @(posedge clock) disable iff (!resetn)
    (wr_en && is_addr(paddr, `DIMC_CLEAR_OFFSET) && pwdata[0]
     && !stream_done[0]) |=> !dma_stream_flags[0])
    else $error("clear write left stream 0 done flag set");

  a_done_clear_s1: assert property (
    @(posedge clock) disable iff (!resetn)
    (wr_en && is_addr(paddr, `DIMC_CLEAR_OFFSET) && pwdata[1]
     && !stream_done[1]) |=> !dma_stream_flags[1])
    else $error("clear write left stream 1 done flag set");

  a_done_clear_s2: assert property (
    @(posedge clock) disable iff (!resetn)
    (wr_en && is_addr(paddr, `DIMC_CLEAR_OFFSET) && pwdata[2]
     && !stream_done[2]) |=> !dma_stream_flags[2])
    else $error("clear write left stream 2 done flag set");

  a_done_clear_s3: assert property (
    @(posedge clock) disable iff (!resetn)
    (wr_en && is_addr(paddr, `DIMC_CLEAR_OFFSET) && pwdata[3]
     && !stream_done[3]) |=> !dma_stream_flags[3])
    else $error("clear write left stream 3 done flag set");

  a_clear_one: assert property (
    @(posedge clock) disable iff (!resetn)
    (wr_en && is_addr(paddr, `DIMC_CLEAR_OFFSET) && pwdata[4]
     && !stream_error[0]) |=> !dma_stream_flags[4])
    else $error("clear write left stream 0 error flag set");

  a_err_clear_s1: assert property (
    @(posedge clock) disable iff (!resetn)
    (wr_en && is_addr(paddr, `DIMC_CLEAR_OFFSET) && pwdata[5]
     && !stream_error[1]) |=> !dma_stream_flags[5])
    else $error("clear write left stream 1 error flag set");

  a_err_clear_s2: assert property (
    @(posedge clock) disable iff (!resetn)
    (wr_en && is_addr(paddr, `DIMC_CLEAR_OFFSET) && pwdata[6]
     && !stream_error[2]) |=> !dma_stream_flags[6])
    else $error("clear write left stream 2 error flag set");

  a_err_clear_s3: assert property (
    @(posedge clock) disable iff (!resetn)
    (wr_en && is_addr(paddr, `DIMC_CLEAR_OFFSET) && pwdata[7]
     && !stream_error[3]) |=> !dma_stream_flags[7])
    else $error("clear write left stream 3 error flag set");

  a_clear_zero: assert property (
    @(posedge clock) disable iff (!resetn)
    (wr_en && is_addr(paddr, `DIMC_CLEAR_OFFSET) && !pwdata[1]
     && dma_stream_flags[1]) |=> dma_stream_flags[1])
    else $error("zero clear bit changed flag");

  a_set_wins: assert property (
    @(posedge clock) disable iff (!resetn)
    (wr_en && is_addr(paddr, `DIMC_CLEAR_OFFSET) && pwdata[2]
     && stream_done[2]) |=> dma_stream_flags[2])
    else $error("clear beat a same-cycle set");

  a_flags_no_drop: assert property (
    @(posedge clock) disable iff (!resetn)
    !wr_en |=> (dma_stream_flags & $past(dma_stream_flags))
      == $past(dma_stream_flags))
    else $error("flag fell without a clear write");

  // ************************************************************
  // Checks: combined interrupt
  // ************************************************************
  a_irq_follows_mask: assert property (
    @(posedge clock) disable iff (!resetn)
    combined_irq == |($past(state_next.flags) & $past(state_next.mask)))
    else $error("combined irq does not match enabled flags");

  a_irq_level: assert property (
    @(posedge clock) disable iff (!resetn)
    combined_irq |-> (|(dma_stream_flags & state_reg.mask)))
    else $error("combined irq without an enabled flag");

  a_done_irq_s0: assert property (
    @(posedge clock) disable iff (!resetn)
    (dma_stream_flags[0] && state_reg.mask.done[0]) |-> combined_irq)
    else $error("enabled stream 0 done flag gives no irq");

  a_done_irq_s1: assert property (
    @(posedge clock) disable iff (!resetn)
    (dma_stream_flags[1] && state_reg.mask.done[1]) |-> combined_irq)
    else $error("enabled stream 1 done flag gives no irq");

  a_done_irq_s2: assert property (
    @(posedge clock) disable iff (!resetn)
    (dma_stream_flags[2] && state_reg.mask.done[2]) |-> combined_irq)
    else $error("enabled stream 2 done flag gives no irq");

  a_done_irq_s3: assert property (
    @(posedge clock) disable iff (!resetn)
    (dma_stream_flags[3] && state_reg.mask.done[3]) |-> combined_irq)
    else $error("enabled stream 3 done flag gives no irq");

  a_err_irq_s0: assert property (
    @(posedge clock) disable iff (!resetn)
    (dma_stream_flags[4] && state_reg.mask.err[0]) |-> combined_irq)
    else $error("enabled stream 0 error flag gives no irq");

  a_err_irq_s1: assert property (
    @(posedge clock) disable iff (!resetn)
    (dma_stream_flags[5] && state_reg.mask.err[1]) |-> combined_irq)
    else $error("enabled stream 1 error flag gives no irq");

  a_err_irq_s2: assert property (
    @(posedge clock) disable iff (!resetn)
    (dma_stream_flags[6] && state_reg.mask.err[2]) |-> combined_irq)
    else $error("enabled stream 2 error flag gives no irq");

  a_err_irq_s3: assert property (
    @(posedge clock) disable iff (!resetn)
    (dma_stream_flags[7] && state_reg.mask.err[3]) |-> combined_irq)
    else $error("enabled stream 3 error flag gives no irq");

endmodule // dimc_irq_ctl
`default_nettype wire

/* verification/dimc_stream_src.sv */
`timescale 1ns/10ps
`default_nettype none
module dimc_stream_src
  import dimc_pkg::*;
(
  input wire logic clock, // Bus clock
  input wire logic resetn, // Async reset, active low
  input wire logic [7:0] req, // Requested events, err 7:4, done 3:0
  input wire logic irq_line, // Combined interrupt from the block
  input wire logic irq_en, // Controller enable of the DMA source
  output var dimc_flags_s ev, // One-cycle stream event pulses
  output var logic irq_taken // Interrupt as the controller sees it
);
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ev <= 8'h00;
      irq_taken <= 1'b0;
    end else begin
      ev <= req;
      irq_taken <= irq_line && irq_en;
    end
  end
endmodule // dimc_stream_src
`default_nettype wire

/* verification/tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
  import dimc_pkg::*;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err_seen, combined_irq;
  logic [3:0] active = 4'h0;
  logic [7:0] req = 8'h00;
  logic irq_en = 1'b0;
  logic irq_taken;
  logic [7:0] flags;
  dimc_flags_s ev;
  int failures = 0;
  int comparisons = 0;
  dimc_irq_ctl DUT (.clock(clock), .resetn(resetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .stream_done(ev.done), .stream_error(ev.err), .stream_active(active),
    .combined_irq(combined_irq), .dma_stream_flags(flags));
  dimc_stream_src src (.clock(clock), .resetn(resetn), .req(req),
    .irq_line(combined_irq), .irq_en(irq_en), .ev(ev),
    .irq_taken(irq_taken));
  initial begin
    forever #50 clock = ~clock;
  end
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic ev_pulse(input logic [7:0] v);
    @(posedge clock);
    req <= v;
    @(posedge clock);
    req <= 8'h00;
    repeat (2) @(posedge clock);
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", s, e, g);
    end
  endtask
  task final_report;
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ****************
  // Tests
  // ****************
  initial begin
    repeat (10) @(posedge clock);
    resetn <= 1'b1;
    active <= 4'ha;
    irq_en <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    chk("mask", 32'h0, rd);
    chk("irq", 32'h0, {31'h0, combined_irq});
    apb(1'b0, 12'h008, 32'h0);
    chk("flags", 32'h0, rd);
    apb(1'b1, 12'h000, 32'h0000005a);
    apb(1'b0, 12'h000, 32'h0);
    chk("mask", 32'h5a, rd);
    ev_pulse(8'hff);
    chk("flag pins", 32'hff, {24'h0, flags});
    chk("irq", 32'h1, {31'h0, combined_irq});
    apb(1'b0, 12'h000, 32'h0);
    chk("mask", 32'h5a, rd);
    apb(1'b0, 12'h008, 32'h0);
    chk("flags", 32'hff, rd);
    apb(1'b1, 12'h004, 32'h000000a5);
    apb(1'b1, 12'h004, 32'h0);
    apb(1'b0, 12'h008, 32'h0);
    chk("flags", 32'h5a, rd);
    chk("irq", 32'h1, {31'h0, combined_irq});
    apb(1'b1, 12'h004, 32'h0000005a);
    apb(1'b0, 12'h008, 32'h0);
    chk("flags", 32'h0, rd);
    chk("irq", 32'h0, {31'h0, combined_irq});
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, 12'h000, 32'h1 << i);
      ev_pulse(~(8'h01 << i));
      chk("irq", 32'h0, {31'h0, combined_irq});
      ev_pulse(8'h01 << i);
      chk("irq", 32'h1, {31'h0, combined_irq});
      apb(1'b1, 12'h004, 32'h000000ff);
      apb(1'b0, 12'h008, 32'h0);
      chk("flags", 32'h0, rd);
    end
    fork
      apb(1'b1, 12'h004, 32'h00000004);
      ev_pulse(8'h04);
    join
    chk("flag pins", 32'h04, {24'h0, flags});
    apb(1'b1, 12'h000, 32'h000000ff);
    repeat (2) @(posedge clock);
    chk("irq taken", 32'h1, {31'h0, irq_taken});
    resetn <= 1'b0;
    repeat (3) @(posedge clock);
    chk("flag pins", 32'h0, {24'h0, flags});
    chk("irq", 32'h0, {31'h0, combined_irq});
    resetn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    chk("mask", 32'h0, rd);
    apb(1'b0, 12'h00c, 32'h0);
    chk("active", 32'ha, rd);
    chk("slverr", 32'h0, {31'h0, err_seen});
    apb(1'b0, 12'h010, 32'h0);
    chk("slverr", 32'h1, {31'h0, err_seen});
    final_report;
  end
  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    final_report;
  end
endmodule // tb
`default_nettype wire
